// ===== ncm_params.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the coprocessor clock mux and PLL sequencer.
 * Assumes inclusion by bare name from the clock controller module.
 */
`ifndef NCM_PARAMS_SVH
`define NCM_PARAMS_SVH

`define NCM_OFS_NET_PLL_CTL1 4'h0
`define NCM_OFS_SEQ_CTL 4'h1
`define NCM_OFS_SEQ_CFG 4'h2
`define NCM_OFS_STATUS 4'h3

`define NCM_CTL1_SEL_BIT 13
`define NCM_CTL1_RESET 32'h0000_0000

`define NCM_SEQ_MUX_EN_BIT 0
`define NCM_SEQ_ENSRC_BIT 1
`define NCM_SEQ_START_BIT 2
`define NCM_SEQ_TARGET_LSB 4

`define NCM_CFG_MULT_LSB 0
`define NCM_CFG_DIV_LSB 13
`define NCM_CFG_BW_LSB 19

`define NCM_RST_HOLD_NS 1000
`define NCM_CLK_PERIOD_NS 10

`endif

// ===== ncm_pkg.sv
/*
 * Types shared by the PLL sequencer and its bench.
 * Assumes the params header is on the include path.
 */
package ncm_pkg;
    typedef enum logic [4:0] {
        NCM_IDLE = 5'b00001,
        NCM_BYPASS = 5'b00010,
        NCM_LOAD = 5'b00100,
        NCM_RESET = 5'b01000,
        NCM_RELEASE = 5'b10000
    } ncm_seq_e;

    typedef logic [1:0] ncm_target_t;
endpackage : ncm_pkg

// ===== ncm_glitch_free_mux.sv
/*
 * Glitch-free two-input clock multiplexer.
 * Assumes both clocks run while a switch is in progress and that the
 * select input is synchronous to neither; each side owns its enable.
 */
module ncm_glitch_free_mux (
    input wire logic i_clk_a,
    input wire logic i_clk_b,
    input wire logic i_sel_b,
    input wire logic i_reset_n,
    output logic o_clk,
    output logic o_sel_b_active
);
    logic a_s1_q;
    logic a_s2_q;
    logic b_s1_q;
    logic b_s2_q;
    logic a_en_q;
    logic b_en_q;

    // Each side waits until the other has stopped before enabling
    always_ff @(posedge i_clk_a) begin
        if (!i_reset_n) begin
            a_s1_q <= 1'b1;
            a_s2_q <= 1'b1;
        end else begin
            a_s1_q <= !i_sel_b && !b_en_q;
            a_s2_q <= a_s1_q;
        end
    end

    always_ff @(negedge i_clk_a) begin
        if (!i_reset_n) begin
            a_en_q <= 1'b1;
        end else begin
            a_en_q <= a_s2_q;
        end
    end

    always_ff @(posedge i_clk_b) begin
        if (!i_reset_n) begin
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
        end else begin
            b_s1_q <= i_sel_b && !a_en_q;
            b_s2_q <= b_s1_q;
        end
    end

    always_ff @(negedge i_clk_b) begin
        if (!i_reset_n) begin
            b_en_q <= 1'b0;
        end else begin
            b_en_q <= b_s2_q;
        end
    end

    // Enables change only while their clock is low, so no pulse is cut
    assign o_clk = (i_clk_a && a_en_q) || (i_clk_b && b_en_q);
    assign o_sel_b_active = b_en_q;
endmodule : ncm_glitch_free_mux

// ===== ncm_clock_ctrl.sv
/*
 * Coprocessor clock select and PLL reprogramming sequencer.
 * Index 0 holds control 1, whose bit 13 picks the coprocessor clock.
 * Index 1 starts a sequence or loads the two bypass bits directly.
 * Index 2 holds the multiplier, divider and bandwidth fields.
 * Index 3 reports busy, live select, synthesizer reset and state.
 * A sequence enters bypass, loads the fields, then pulses reset.
 * Assumes a register master on i_clk, single-cycle strobes, read data
 * taken the cycle after the read strobe; PLL clock is free running.
 */
`include "ncm_params.svh"

module ncm_clock_ctrl #(
    parameter int MULT_W = 13,
    parameter int DIV_W = 6,
    parameter int BW_W = 12
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_net_pll_clk,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_coproc_clk,
    output logic o_net_pll_sel_active,
    output logic [1:0] o_pll_target,
    output logic o_bypass_mux_enable_bit,
    output logic o_enable_source_select_bit,
    output logic [MULT_W-1:0] o_multiplier_field,
    output logic [DIV_W-1:0] o_divider_field,
    output logic [BW_W-1:0] o_bandwidth_adjust_field,
    output logic o_synthesizer_reset_signal,
    output logic o_seq_busy
);
    // Synthesizer reset hold, rounded up to whole clock cycles
    localparam int RST_CYC = (`NCM_RST_HOLD_NS + `NCM_CLK_PERIOD_NS - 1) / `NCM_CLK_PERIOD_NS;
    localparam logic [7:0] RST_CYC_M1 = 8'(RST_CYC - 1);

    logic [31:0] ctl1_q;
    logic [31:0] ctl1_d;
    logic mux_en_q;
    logic mux_en_d;
    logic ensrc_q;
    logic ensrc_d;
    ncm_pkg::ncm_target_t target_q;
    ncm_pkg::ncm_target_t target_d;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [MULT_W-1:0] mult_q;
    logic [MULT_W-1:0] mult_d;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [BW_W-1:0] bw_q;
    logic [BW_W-1:0] bw_d;
    logic prst_q;
    logic prst_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic sel_active;
    ncm_pkg::ncm_seq_e st_q;
    ncm_pkg::ncm_seq_e st_d;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic seq_running(input ncm_pkg::ncm_seq_e st);
        seq_running = (st != ncm_pkg::NCM_IDLE);
    endfunction : seq_running

    // Register writes and read mux
    always_comb begin
        ctl1_d = ctl1_q;
        cfg_d = cfg_q;
        target_d = target_q;
        rdata_d = 32'h0000_0000;
        if (i_wr && hit(i_addr, `NCM_OFS_NET_PLL_CTL1)) begin
            ctl1_d = i_wdata;
        end
        if (i_wr && hit(i_addr, `NCM_OFS_SEQ_CFG)) begin
            cfg_d = i_wdata;
        end
        // Control writes are dropped while a sequence runs
        if (i_wr && hit(i_addr, `NCM_OFS_SEQ_CTL) && !seq_running(st_q)) begin
            target_d = i_wdata[`NCM_SEQ_TARGET_LSB +: 2];
        end
        if (i_rd) begin
            case (i_addr)
                `NCM_OFS_NET_PLL_CTL1: rdata_d = ctl1_q;
                `NCM_OFS_SEQ_CTL: begin
                    rdata_d[`NCM_SEQ_MUX_EN_BIT] = mux_en_q;
                    rdata_d[`NCM_SEQ_ENSRC_BIT] = ensrc_q;
                    rdata_d[`NCM_SEQ_TARGET_LSB +: 2] = target_q;
                end
                `NCM_OFS_SEQ_CFG: rdata_d = cfg_q;
                `NCM_OFS_STATUS: begin
                    rdata_d[0] = seq_running(st_q);
                    rdata_d[1] = sel_active;
                    rdata_d[2] = prst_q;
                    rdata_d[7:3] = st_q;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Sequencer: bypass, load fields, then pulse synthesizer reset
    always_comb begin
        st_d = st_q;
        mux_en_d = mux_en_q;
        ensrc_d = ensrc_q;
        mult_d = mult_q;
        div_d = div_q;
        bw_d = bw_q;
        prst_d = 1'b0;
        cnt_d = cnt_q;
        case (st_q)
            ncm_pkg::NCM_IDLE: begin
                if (i_wr && hit(i_addr, `NCM_OFS_SEQ_CTL)) begin
                    // Start bit is never stored; it only launches the sequence
                    if (i_wdata[`NCM_SEQ_START_BIT]) begin
                        st_d = ncm_pkg::NCM_BYPASS;
                    end else begin
                        mux_en_d = i_wdata[`NCM_SEQ_MUX_EN_BIT];
                        ensrc_d = i_wdata[`NCM_SEQ_ENSRC_BIT];
                    end
                end
            end
            ncm_pkg::NCM_BYPASS: begin
                // Bypass first so the cores never run on a relocking PLL
                mux_en_d = 1'b0;
                ensrc_d = 1'b0;
                st_d = ncm_pkg::NCM_LOAD;
            end
            ncm_pkg::NCM_LOAD: begin
                // Fields settle a full cycle before reset rises
                mult_d = cfg_q[`NCM_CFG_MULT_LSB +: MULT_W];
                div_d = cfg_q[`NCM_CFG_DIV_LSB +: DIV_W];
                bw_d = cfg_q[`NCM_CFG_BW_LSB +: BW_W];
                cnt_d = RST_CYC_M1;
                st_d = ncm_pkg::NCM_RESET;
            end
            ncm_pkg::NCM_RESET: begin
                // Held through the last count so the pulse spans RST_CYC cycles
                prst_d = 1'b1;
                if (cnt_q == 8'h00) begin
                    st_d = ncm_pkg::NCM_RELEASE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            ncm_pkg::NCM_RELEASE: begin
                st_d = ncm_pkg::NCM_IDLE;
            end
            default: st_d = ncm_pkg::NCM_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctl1_q <= `NCM_CTL1_RESET;
            cfg_q <= 32'h0000_0000;
            target_q <= 2'h0;
            mux_en_q <= 1'b0;
            ensrc_q <= 1'b0;
            mult_q <= '0;
            div_q <= '0;
            bw_q <= '0;
            prst_q <= 1'b0;
            cnt_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            st_q <= ncm_pkg::NCM_IDLE;
        end else begin
            ctl1_q <= ctl1_d;
            cfg_q <= cfg_d;
            target_q <= target_d;
            mux_en_q <= mux_en_d;
            ensrc_q <= ensrc_d;
            mult_q <= mult_d;
            div_q <= div_d;
            bw_q <= bw_d;
            prst_q <= prst_d;
            cnt_q <= cnt_d;
            rdata_q <= rdata_d;
            st_q <= st_d;
        end
    end

    // The select crosses into both clock domains inside the mux
    ncm_glitch_free_mux u_mux (
        .i_clk_a(i_clk),
        .i_clk_b(i_net_pll_clk),
        .i_sel_b(ctl1_q[`NCM_CTL1_SEL_BIT]),
        .i_reset_n(i_reset_n),
        .o_clk(o_coproc_clk),
        .o_sel_b_active(sel_active)
    );

    // Field and bypass outputs come straight from registers
    assign o_rdata = rdata_q;
    assign o_net_pll_sel_active = sel_active;
    assign o_pll_target = target_q;
    assign o_bypass_mux_enable_bit = mux_en_q;
    assign o_enable_source_select_bit = ensrc_q;
    assign o_multiplier_field = mult_q;
    assign o_divider_field = div_q;
    assign o_bandwidth_adjust_field = bw_q;
    assign o_synthesizer_reset_signal = prst_q;
    assign o_seq_busy = seq_running(st_q);
endmodule : ncm_clock_ctrl

// ===== ncm_pll_model.sv
/* Free-running network PLL output clock for the bench.
   Assumes nothing else drives the mux's second clock input. */
module ncm_pll_model #(
    parameter real HALF_NS = 6.5
) (
    output logic o_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // Runs free: the mux needs both clocks alive to finish a switch
    initial begin
        o_clk = 1'b0;
        forever #(HALF_NS) o_clk = ~o_clk;
    end
endmodule : ncm_pll_model

// ===== ncm_clock_ctrl_properties.sv
/* Concurrent checks of the coprocessor clock controller.
   Assumes binding to ncm_clock_ctrl; sees its ports only. */
module ncm_clock_ctrl_properties #(
    parameter int MULT_W = 13,
    parameter int DIV_W = 6,
    parameter int BW_W = 12
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_net_pll_clk,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_coproc_clk,
    input wire logic o_net_pll_sel_active,
    input wire logic [1:0] o_pll_target,
    input wire logic o_bypass_mux_enable_bit,
    input wire logic o_enable_source_select_bit,
    input wire logic [MULT_W-1:0] o_multiplier_field,
    input wire logic [DIV_W-1:0] o_divider_field,
    input wire logic [BW_W-1:0] o_bandwidth_adjust_field,
    input wire logic o_synthesizer_reset_signal,
    input wire logic o_seq_busy
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic [7:0] hold_q;
    // Length of the current PLL reset pulse
    always_ff @(posedge i_clk) begin
        hold_q <= o_synthesizer_reset_signal ? hold_q + 8'h1 : 8'h0;
    end
    sequence s_start;
        i_wr && i_addr == 4'h1 && i_wdata[2] && !o_seq_busy;
    endsequence
    sequence s_bypass;
        !o_bypass_mux_enable_bit && !o_enable_source_select_bit;
    endsequence
    property p_sel_on;
        i_wr && i_addr == 4'h0 && i_wdata[13] |-> ##[1:8] o_net_pll_sel_active;
    endproperty
    a_sel_on: assert property (p_sel_on) else $error("pll select not taken");
    property p_sel_off;
        i_wr && i_addr == 4'h0 && !i_wdata[13] |-> ##[1:8] !o_net_pll_sel_active;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("system clock not restored");
    property p_reset_sel;
        $rose(i_reset_n) |-> !o_net_pll_sel_active && o_rdata == 32'h0;
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("select not clear at reset");
    property p_seq_bypass;
        s_start |-> ##[1:3] s_bypass;
    endproperty
    a_seq_bypass: assert property (p_seq_bypass) else $error("bypass not entered");
    property p_fields_first;
        $rose(o_synthesizer_reset_signal) |-> $stable(o_multiplier_field)
            && $stable(o_divider_field) && $stable(o_bandwidth_adjust_field) ##0 s_bypass;
    endproperty
    a_fields_first: assert property (p_fields_first) else $error("reset before fields");
    property p_reset_len;
        $fell(o_synthesizer_reset_signal) |-> hold_q == 8'h64;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("pll reset length wrong");
    property p_busy_span;
        s_start |=> o_seq_busy [*8];
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("sequence ended early");
endmodule : ncm_clock_ctrl_properties

bind ncm_clock_ctrl ncm_clock_ctrl_properties #(.MULT_W(MULT_W), .DIV_W(DIV_W), .BW_W(BW_W))
    u_props (.*);

// ===== ncm_clock_ctrl_bench.sv
/* Self-checking bench of the coprocessor clock controller.
   Assumes the PLL clock model and the bound checker are compiled. */
module ncm_clock_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_reset_n, i_wr, i_rd, pll_clk, coproc_clk, sel, bypass, ensrc, synth, busy;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata, v, cfg;
    logic [1:0] target;
    logic [12:0] mult, f_mult;
    logic [5:0] div, f_div;
    logic [11:0] bw, f_bw;
    int num_errors, comparisons;
    realtime t_edge, t0;
    ncm_pll_model u_pll (.o_clk(pll_clk));
    ncm_clock_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_net_pll_clk(pll_clk),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_coproc_clk(coproc_clk), .o_net_pll_sel_active(sel), .o_pll_target(target),
        .o_bypass_mux_enable_bit(bypass), .o_enable_source_select_bit(ensrc),
        .o_multiplier_field(f_mult), .o_divider_field(f_div), .o_bandwidth_adjust_field(f_bw),
        .o_synthesizer_reset_signal(synth), .o_seq_busy(busy));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    function automatic logic [31:0] status_word(input ncm_pkg::ncm_seq_e st, input logic [2:0] f);
        return {24'h0, st, f};
    endfunction : status_word
    task automatic end_of_test;
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // No clock pulse narrower than the faster clock's half period
    always @(coproc_clk) begin
        if (i_reset_n === 1'b1) check(32'(($realtime - t_edge) > 4.9), 32'h1);
        t_edge = $realtime;
    end
    initial begin
        #50000;
        num_errors++;
        end_of_test();
    end
    initial begin
        {i_reset_n, i_wr, i_rd, i_addr, i_wdata} = '0;
        num_errors = 0;
        comparisons = 0;
        t_edge = 0;
        void'($urandom(93));
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(4'h0, v);
        check(v, 32'h0);
        check({31'h0, sel}, 32'h0);
        cfg = $urandom() & ~32'h2000;
        wr(4'h0, cfg);
        rd(4'h0, v);
        check(v, cfg);
        wr(4'h0, v | 32'h2000);
        repeat (10) @(posedge i_clk);
        rd(4'h0, v);
        check(v, cfg | 32'h2000);
        check({31'h0, sel}, 32'h1);
        @(posedge coproc_clk) t0 = $realtime;
        @(posedge coproc_clk) check(32'(int'(($realtime - t0) * 10.0)), 32'h82);
        for (int t = 0; t < 3; t++) begin
            mult = (t == 0) ? 13'h1fff : 13'($urandom());
            div = 6'($urandom());
            bw = (t == 2) ? 12'hfff : 12'($urandom());
            wr(4'h2, {1'b0, bw, div, mult});
            rd(4'h2, v);
            check(v, {1'b0, bw, div, mult});
            wr(4'h1, 32'h3);
            #1 check({30'h0, ensrc, bypass}, 32'h3);
            wr(4'h1, {26'h0, 2'(t), 4'h4});
            wr(4'h1, 32'h3);
            rd(4'h3, v);
            check(v, status_word(ncm_pkg::NCM_RESET, 3'h7));
            #1;
            for (int n = 0; n < 300 && busy !== 1'b0; n++) begin
                @(posedge i_clk);
                #1;
            end
            check({31'h0, busy}, 32'h0);
            check({1'b0, f_bw, f_div, f_mult}, {1'b0, bw, div, mult});
            check({30'h0, ensrc, bypass}, 32'h0);
            check({30'h0, target}, 32'(t));
            rd(4'h3, v);
            check(v, status_word(ncm_pkg::NCM_IDLE, 3'h2));
            rd(4'h1, v);
            check(v, {26'h0, 2'(t), 4'h0});
        end
        rd(4'h7, v);
        check(v, 32'h0);
        wr(4'h0, cfg);
        repeat (10) @(posedge i_clk);
        check({31'h0, sel}, 32'h0);
        @(posedge coproc_clk) t0 = $realtime;
        @(posedge coproc_clk) check(32'(int'(($realtime - t0) * 10.0)), 32'h64);
        end_of_test();
    end
endmodule : ncm_clock_ctrl_bench
